//--- verilog/oaa_core.sv
// Output routing, display/program options, rate-of-change alarm and heater overcurrent alarm.
// Assumes mode, source and tick inputs come from logic on aclk; latch-cancel keys are pins.
//
// Summary of operation
// - Aux output 2 routes one source of sixteen; default second alarm.
// - Aux output 3 offers the same sources; default third alarm.
// - Cooling routed under heating-only control outputs zero, as 0% MV.
// - Program end routed while program is off keeps the output inactive.
// - Heating/cooling without control output 2 forces aux output 2 to cooling.
// - Work-bit sources cannot be selected when logic operation is unused.
// - Changing an assignment while program runs switches it to program end.
// - Glyph style bit: on gives 11-segment, off 7-segment; default on.
// - Soak time unit bit: minutes or hours; default minutes.
// - Deviation alarms use ramping or target set point; default ramping.
// - Manual output limit only under two-degree PID; default disabled.
// - Rate alarm compares PV difference per period with alarm value.
// - Rate period is 1 to 999 ticks of 250 ms; default 4.
// - Automatic cooling coefficient tuning enable; default off.
// - Overcurrent enable gates the overcurrent alarm; default enabled.
// - Latched overcurrent alarm holds until 50.0 A, reset or cancel.
// - Latched overcurrent output clears on entering a setting level.
// - Hysteresis 0.1 to 50.0 A applies only when used and unlatched.
// - Latch cancel clears all alarm latches together.
`timescale 1ns/1ns
module oaa_core
  import oaa_pkg::*;
(
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]   s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  input  wire logic [7:0]   s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  // Controller state and sources
  input  wire oaa_mode_t    mode,
  input  wire oaa_sources_t src,
  input  wire logic         sample_tick,
  input  wire logic [15:0]  process_value,
  input  wire logic [9:0]   heater_current,
  // Latch cancel pins
  input  wire logic         function_key,
  input  wire logic         event_cancel,
  // Outputs
  output logic              aux_out2,
  output logic              aux_out3,
  output logic              glyph_style_sel,
  output logic              soak_unit_hours,
  output logic              alarm_setpoint_source,
  output logic              manual_output_limit_en,
  output logic              auto_cool_coeff_tune,
  output logic              rate_alarm,
  output logic              overcurrent_alarm,
  output logic              latch_cancel_cmd
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        aw_ok;
    logic [7:0]  aw_addr;
    logic        w_ok;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        aw_rdy, w_rdy, ar_rdy;
    oaa_src_t    sel2;
    oaa_src_t    sel3;
    logic        glyph;
    logic        hours;
    logic        target_sp;
    logic        man_lim;
    logic        man_out;
    logic        auto_cool;
    logic        oc_use;
    logic        oc_latch;
    logic [9:0]  period;
    logic [9:0]  tick_cnt;
    logic [15:0] pv_prev;
    logic [15:0] alm_val;
    logic [9:0]  oc_thr;
    logic [9:0]  oc_hys;
    logic        oc_raw;
    logic        oc_out;
    logic        rate;
    logic        aux2;
    logic        aux3;
    logic        cancel;
    logic        level_prev;
    logic [2:0]  fk_sync;
    logic [2:0]  ev_sync;
    logic        fk_st;
    logic        ev_st;
  } oaa_state_t;

  oaa_state_t st_reg;
  oaa_state_t st_next;

  function automatic logic route(input oaa_src_t sel, input oaa_sources_t s, input oaa_mode_t m);
    logic r;
    r = 1'b0;
    if (sel >= logic_flag_first) begin
      r = s.work_bits[3'(sel - logic_flag_first)];
    end else begin
      unique case (sel)
        no_source:          r = 1'b0;
        src_heat:           r = s.heat_out;
        src_cool:           r = s.cool_out & m.heat_cool_mode;
        src_first_alarm:    r = s.alarm[0];
        second_alarm:       r = s.alarm[1];
        third_alarm:        r = s.alarm[2];
        src_program_end:    r = s.program_end & m.program_on;
        switch_count_alarm: r = s.switch_count;
        default:            r = 1'b0;
      endcase
    end
    return r;
  endfunction : route

  function automatic oaa_src_t pick(input oaa_src_t old, input logic [3:0] req, input oaa_mode_t m);
    oaa_src_t r;
    r = old;
    if (req >= 4'(logic_flag_first) && !m.logic_op_used) begin
      r = old;
    end else if (m.program_on && req != 4'(old)) begin
      r = src_program_end;
    end else begin
      r = oaa_src_t'(req);
    end
    return r;
  endfunction : pick

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      r[i*8 +: 8] = be[i] ? d[i*8 +: 8] : old[i*8 +: 8];
    end
    return r;
  endfunction : merge

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  logic [31:0]        ctrl_word;
  logic [31:0]        wval;
  logic               do_write;
  logic               period_end;
  logic signed [16:0] pv_diff;
  logic               oc_clear;
  logic [10:0]        cur_plus_hys;

  always_comb begin
    st_next = st_reg;
    ctrl_word = 32'h0000_0000;
    ctrl_word[OAA_CTRL_SEL2_LSB +: 4] = st_reg.sel2;
    ctrl_word[OAA_CTRL_SEL3_LSB +: 4] = st_reg.sel3;
    ctrl_word[OAA_CTRL_GLYPH]      = st_reg.glyph;
    ctrl_word[OAA_CTRL_SOAK_HOURS] = st_reg.hours;
    ctrl_word[OAA_CTRL_TARGET_SP]  = st_reg.target_sp;
    ctrl_word[OAA_CTRL_MAN_LIM]    = st_reg.man_lim;
    ctrl_word[OAA_CTRL_AUTO_COOL]  = st_reg.auto_cool;
    ctrl_word[OAA_CTRL_OC_USE]     = st_reg.oc_use;
    ctrl_word[OAA_CTRL_OC_LATCH]   = st_reg.oc_latch;
    wval = 32'h0000_0000;
    st_next.cancel = 1'b0;

    // Write channel: address and data are taken in either order.
    if (s_axi_awvalid && !st_reg.aw_ok && !st_reg.bvalid) begin
      st_next.aw_ok = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_reg.w_ok && !st_reg.bvalid) begin
      st_next.w_ok = 1'b1;
      st_next.wdata = s_axi_wdata;
      st_next.wstrb = s_axi_wstrb;
    end
    do_write = st_reg.aw_ok && st_reg.w_ok;
    if (do_write) begin
      st_next.aw_ok = 1'b0;
      st_next.w_ok = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = OAA_RESP_OKAY;
      unique case ({st_reg.aw_addr[7:2], 2'b00})
        OAA_ADDR_CTRL: begin
          wval = merge(ctrl_word, st_reg.wdata, st_reg.wstrb);
          st_next.sel2 = pick(st_reg.sel2, wval[OAA_CTRL_SEL2_LSB +: 4], mode);
          st_next.sel3 = pick(st_reg.sel3, wval[OAA_CTRL_SEL3_LSB +: 4], mode);
          st_next.glyph = wval[OAA_CTRL_GLYPH];
          st_next.hours = wval[OAA_CTRL_SOAK_HOURS];
          st_next.target_sp = wval[OAA_CTRL_TARGET_SP];
          st_next.man_lim = wval[OAA_CTRL_MAN_LIM];
          st_next.auto_cool = wval[OAA_CTRL_AUTO_COOL];
          st_next.oc_use = wval[OAA_CTRL_OC_USE];
          st_next.oc_latch = wval[OAA_CTRL_OC_LATCH];
        end
        OAA_ADDR_PERIOD: begin
          wval = merge({22'h0, st_reg.period}, st_reg.wdata, st_reg.wstrb);
          if (wval[31:0] < 32'(OAA_PERIOD_MIN)) begin
            st_next.period = OAA_PERIOD_MIN;
          end else if (wval[31:0] > 32'(OAA_PERIOD_MAX)) begin
            st_next.period = OAA_PERIOD_MAX;
          end else begin
            st_next.period = wval[9:0];
          end
        end
        OAA_ADDR_OC_THR: begin
          wval = merge({22'h0, st_reg.oc_thr}, st_reg.wdata, st_reg.wstrb);
          st_next.oc_thr = (wval[31:0] > 32'(OAA_OC_THR_OFF)) ? OAA_OC_THR_OFF : wval[9:0];
        end
        OAA_ADDR_OC_HYS: begin
          wval = merge({22'h0, st_reg.oc_hys}, st_reg.wdata, st_reg.wstrb);
          if (wval[31:0] < 32'(OAA_OC_HYS_MIN)) begin
            st_next.oc_hys = OAA_OC_HYS_MIN;
          end else if (wval[31:0] > 32'(OAA_OC_THR_OFF)) begin
            st_next.oc_hys = OAA_OC_THR_OFF;
          end else begin
            st_next.oc_hys = wval[9:0];
          end
        end
        OAA_ADDR_ALMVAL: begin
          wval = merge({16'h0, st_reg.alm_val}, st_reg.wdata, st_reg.wstrb);
          st_next.alm_val = wval[15:0];
        end
        OAA_ADDR_CMD:    st_next.cancel = st_reg.wstrb[0] & st_reg.wdata[OAA_CMD_CANCEL];
        OAA_ADDR_STATUS: st_next.bresp = OAA_RESP_OKAY;
        default:         st_next.bresp = OAA_RESP_SLVERR;
      endcase
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end

    // Read channel.
    if (s_axi_arvalid && !st_reg.rvalid) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = OAA_RESP_OKAY;
      st_next.rdata = 32'h0000_0000;
      unique case ({s_axi_araddr[7:2], 2'b00})
        OAA_ADDR_CTRL:   st_next.rdata = ctrl_word;
        OAA_ADDR_PERIOD: st_next.rdata = {22'h0, st_reg.period};
        OAA_ADDR_OC_THR: st_next.rdata = {22'h0, st_reg.oc_thr};
        OAA_ADDR_OC_HYS: st_next.rdata = {22'h0, st_reg.oc_hys};
        OAA_ADDR_ALMVAL: st_next.rdata = {16'h0, st_reg.alm_val};
        OAA_ADDR_STATUS: st_next.rdata = {27'h0, st_reg.oc_raw, st_reg.oc_out, st_reg.rate,
                                          st_reg.aux3, st_reg.aux2};
        OAA_ADDR_CMD:    st_next.rdata = 32'h0000_0000;
        default:         st_next.rresp = OAA_RESP_SLVERR;
      endcase
    end else if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    st_next.aw_rdy = !st_next.aw_ok && !st_next.bvalid;
    st_next.w_rdy  = !st_next.w_ok && !st_next.bvalid;
    st_next.ar_rdy = !st_next.rvalid;

    // Heating/cooling on a unit without control output 2 takes aux output 2 as cooling.
    if (mode.heat_cool_mode && !mode.has_ctrl_out2) begin
      st_next.sel2 = src_cool;
    end

    // Routing of the auxiliary outputs.
    st_next.aux2 = route(st_reg.sel2, src, mode);
    st_next.aux3 = route(st_reg.sel3, src, mode);
    st_next.man_out = st_next.man_lim & mode.two_dof_pid;

    // Pin synchronisers: a change counts once stages two and three agree.
    st_next.fk_sync = {st_reg.fk_sync[1:0], function_key};
    st_next.ev_sync = {st_reg.ev_sync[1:0], event_cancel};
    st_next.fk_st = (st_reg.fk_sync[2] == st_reg.fk_sync[1]) ? st_reg.fk_sync[2] : st_reg.fk_st;
    st_next.ev_st = (st_reg.ev_sync[2] == st_reg.ev_sync[1]) ? st_reg.ev_sync[2] : st_reg.ev_st;
    if ((st_next.fk_st && !st_reg.fk_st) || (st_next.ev_st && !st_reg.ev_st)) begin
      st_next.cancel = 1'b1;
    end

    // Rate-of-change alarm, evaluated at the end of each period.
    period_end = sample_tick && (st_reg.tick_cnt + 10'h001 >= st_reg.period);
    pv_diff = 17'($signed(process_value)) - 17'($signed(st_reg.pv_prev));
    if (sample_tick) begin
      st_next.tick_cnt = period_end ? 10'h000 : st_reg.tick_cnt + 10'h001;
    end
    if (period_end) begin
      st_next.pv_prev = process_value;
      st_next.rate = pv_diff > 17'($signed(st_reg.alm_val));
    end

    // Heater overcurrent detection with hysteresis only when unlatched.
    cur_plus_hys = {1'b0, heater_current} + (st_reg.oc_latch ? 11'h000 : {1'b0, st_reg.oc_hys});
    if (!st_reg.oc_use) begin
      st_next.oc_raw = 1'b0;
    end else if (heater_current > st_reg.oc_thr) begin
      st_next.oc_raw = 1'b1;
    end else if (cur_plus_hys < {1'b0, st_reg.oc_thr}) begin
      st_next.oc_raw = 1'b0;
    end
    st_next.level_prev = mode.setting_level;
    oc_clear = st_reg.cancel || (st_reg.oc_thr == OAA_OC_THR_OFF)
               || (mode.setting_level && !st_reg.level_prev);
    st_next.oc_out = st_reg.oc_use &
                     (st_next.oc_raw | (st_reg.oc_latch & st_reg.oc_out & !oc_clear));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
      st_reg.sel2 <= second_alarm;
      st_reg.sel3 <= third_alarm;
      st_reg.glyph <= 1'b1;
      st_reg.oc_use <= 1'b1;
      st_reg.period <= OAA_PERIOD_RST;
      st_reg.oc_thr <= OAA_OC_THR_OFF;
      st_reg.oc_hys <= OAA_OC_HYS_RST;
      st_reg.alm_val <= OAA_ALMVAL_RST;
      {st_reg.aw_rdy, st_reg.w_rdy, st_reg.ar_rdy} <= 3'h7;
    end else begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign s_axi_awready          = st_reg.aw_rdy;
  assign s_axi_wready           = st_reg.w_rdy;
  assign s_axi_bvalid           = st_reg.bvalid;
  assign s_axi_bresp            = st_reg.bresp;
  assign s_axi_arready          = st_reg.ar_rdy;
  assign s_axi_rvalid           = st_reg.rvalid;
  assign s_axi_rdata            = st_reg.rdata;
  assign s_axi_rresp            = st_reg.rresp;
  assign aux_out2               = st_reg.aux2;
  assign aux_out3               = st_reg.aux3;
  assign glyph_style_sel        = st_reg.glyph;
  assign soak_unit_hours        = st_reg.hours;
  assign alarm_setpoint_source  = st_reg.target_sp;
  assign manual_output_limit_en = st_reg.man_out;
  assign auto_cool_coeff_tune   = st_reg.auto_cool;
  assign rate_alarm             = st_reg.rate;
  assign overcurrent_alarm      = st_reg.oc_out;
  assign latch_cancel_cmd       = st_reg.cancel;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_forced_cool_sel: assert property (mode.heat_cool_mode && !mode.has_ctrl_out2 |=> st_reg.sel2 == src_cool)
    else $error("aux output 2 not forced to cooling");
  a_cool_zero_out: assert property (st_reg.sel3 == src_cool && !mode.heat_cool_mode |=> !aux_out3)
    else $error("cooling routed under standard control is not zero");
  a_pend_off_idle: assert property (st_reg.sel2 == src_program_end && !mode.program_on |=> !aux_out2)
    else $error("program end drives output while program is off");
  a_work_bit_hidden: assert property (!mode.logic_op_used && st_reg.sel3 < logic_flag_first
    |=> st_reg.sel3 < logic_flag_first)
    else $error("work bit selected without logic operation");
  a_period_in_range: assert property (st_reg.period >= OAA_PERIOD_MIN && st_reg.period <= OAA_PERIOD_MAX)
    else $error("rate period out of range");
  a_rate_eval_end: assert property (period_end
    |=> rate_alarm == ($past(pv_diff) > 17'($signed($past(st_reg.alm_val)))))
    else $error("rate alarm wrong at end of period");
  a_oc_use_gate: assert property (!st_reg.oc_use |=> !overcurrent_alarm)
    else $error("overcurrent alarm while disabled");
  a_latch_clear_oc: assert property (oc_clear |=> overcurrent_alarm == st_reg.oc_raw)
    else $error("overcurrent latch not cleared");
  a_latch_hold_oc: assert property (st_reg.oc_latch && st_reg.oc_use && overcurrent_alarm && !oc_clear
    ##0 $stable(st_reg.oc_latch) |=> overcurrent_alarm)
    else $error("latched overcurrent alarm dropped");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");

endmodule : oaa_core

//--- verilog/oaa_pkg.sv
// Package of the output assignment and alarm option block.
// Assumes a 32-bit AXI4-Lite register bus and a 250 ms sampling tick from the controller.
package oaa_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] OAA_ADDR_CTRL   = 8'h00;
  localparam logic [7:0] OAA_ADDR_PERIOD = 8'h04;
  localparam logic [7:0] OAA_ADDR_OC_THR = 8'h08;
  localparam logic [7:0] OAA_ADDR_OC_HYS = 8'h0C;
  localparam logic [7:0] OAA_ADDR_ALMVAL = 8'h10;
  localparam logic [7:0] OAA_ADDR_STATUS = 8'h14;
  localparam logic [7:0] OAA_ADDR_CMD    = 8'h18;

  // Control register fields.
  localparam int OAA_CTRL_SEL2_LSB   = 0;
  localparam int OAA_CTRL_SEL3_LSB   = 4;
  localparam int OAA_CTRL_GLYPH      = 8;
  localparam int OAA_CTRL_SOAK_HOURS = 9;
  localparam int OAA_CTRL_TARGET_SP  = 10;
  localparam int OAA_CTRL_MAN_LIM    = 11;
  localparam int OAA_CTRL_AUTO_COOL  = 12;
  localparam int OAA_CTRL_OC_USE     = 13;
  localparam int OAA_CTRL_OC_LATCH   = 14;
  localparam int OAA_CMD_CANCEL      = 0;

  localparam logic [1:0] OAA_RESP_OKAY   = 2'h0;
  localparam logic [1:0] OAA_RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // Sources and limits
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    no_source          = 4'h0,
    src_heat           = 4'h1,
    src_cool           = 4'h2,
    src_first_alarm    = 4'h3,
    second_alarm       = 4'h4,
    third_alarm        = 4'h5,
    src_program_end    = 4'h6,
    switch_count_alarm = 4'h7,
    logic_flag_first   = 4'h8,
    logic_flag_eighth  = 4'hF
  } oaa_src_t;

  localparam logic [9:0]  OAA_PERIOD_MIN   = 10'h001;
  localparam logic [9:0]  OAA_PERIOD_MAX   = 10'h3E7;
  localparam logic [9:0]  OAA_PERIOD_RST   = 10'h004;
  // Currents in units of 0.1 A: 50.0 A and 0.1 A.
  localparam logic [9:0]  OAA_OC_THR_OFF   = 10'h1F4;
  localparam logic [9:0]  OAA_OC_HYS_MIN   = 10'h001;
  localparam logic [9:0]  OAA_OC_HYS_RST   = 10'h001;
  localparam logic [15:0] OAA_ALMVAL_RST   = 16'h0000;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       heat_out;
    logic       cool_out;
    logic [2:0] alarm;
    logic       program_end;
    logic       switch_count;
    logic [7:0] work_bits;
  } oaa_sources_t;

  typedef struct packed {
    logic heat_cool_mode;
    logic two_dof_pid;
    logic has_ctrl_out2;
    logic program_on;
    logic logic_op_used;
    logic setting_level;
  } oaa_mode_t;

endpackage : oaa_pkg

//--- test/oaa_sensor.sv
// Heater current sensor and sampling tick source for the option block bench.
// Assumes one clock; the tick is shortened to every fourth cycle.
`timescale 1ns/1ns
module oaa_sensor (
  // Clock
  aclk,
  // Commanded current and readings
  level,
  heater_current,
  sample_tick
);
  input  wire logic       aclk;
  input  wire logic [9:0] level;
  output logic [9:0]      heater_current = 10'h000;
  output logic            sample_tick    = 1'h0;
  logic [1:0]             cnt_reg        = 2'h0;

  // The reading lags the command by one clock cycle, as a real converter would.
  always_ff @(posedge aclk) begin
    cnt_reg        <= cnt_reg + 2'h1;
    sample_tick    <= (cnt_reg == 2'h3);
    heater_current <= level;
  end
endmodule : oaa_sensor

//--- test/output_assign_alarm_options_bench.sv
// Self-checking bench of the output assignment and alarm option block.
// Assumes the sensor model for current and ticks; registers are reached over AXI4-Lite.
`timescale 1ns/1ns
module output_assign_alarm_options_bench;
  import oaa_pkg::*;
  logic         aclk = 1'h0, aresetn = 1'h0, awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0;
  logic         awr, wrd, bv, arr, rv, tick, fkey = 1'h0, aux2, aux3, mlim, rate, oc;
  logic         ev = 1'h0, glyph, hrs, tsp, acool, lcan;
  logic [7:0]   awa = 8'h00, ara = 8'h00;
  logic [31:0]  wd = 32'h0, rdat, v;
  logic [1:0]   br, rr, r;
  logic [9:0]   lvl = 10'h000, cur;
  logic [15:0]  pv = 16'h0000;
  oaa_mode_t    mode = '0;
  oaa_sources_t src = '0;
  int           error_cnt = 0, cmp_count = 0, cyc = 0, lc_n = 0;

  always #2 aclk = ~aclk;

  oaa_sensor u_sens (.aclk(aclk), .level(lvl), .heater_current(cur), .sample_tick(tick));
  oaa_core DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .mode(mode), .src(src),
    .sample_tick(tick), .process_value(pv), .heater_current(cur), .function_key(fkey), .event_cancel(ev),
    .aux_out2(aux2), .aux_out3(aux3), .glyph_style_sel(glyph), .soak_unit_hours(hrs), .alarm_setpoint_source(tsp),
    .manual_output_limit_en(mlim), .auto_cool_coeff_tune(acool), .rate_alarm(rate), .overcurrent_alarm(oc),
    .latch_cancel_cmd(lcan));

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim

  always @(posedge aclk) begin
    cyc++;
    lc_n += (lcan === 1'h1);
    if (cyc == 12000) begin
      error_cnt++;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
  endtask : settle

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    awa <= a;
    wd  <= d;
    awv <= 1'h1;
    wv  <= 1'h1;
    bry <= 1'h1;
    fork
      begin do @(posedge aclk); while (awr !== 1'h1); awv <= 1'h0; end
      begin do @(posedge aclk); while (wrd !== 1'h1); wv <= 1'h0; end
    join
    do @(posedge aclk); while (bv !== 1'h1);
    resp = br;
    bry <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    ara <= a;
    arv <= 1'h1;
    rry <= 1'h1;
    do @(posedge aclk); while (arr !== 1'h1);
    arv <= 1'h0;
    do @(posedge aclk); while (rv !== 1'h1);
    d = rdat;
    rry <= 1'h0;
  endtask : rd

  function automatic oaa_sources_t one(input int c);
    logic [14:0] s;
    s = 15'h0000;
    case (c)
      0: s = 15'h0000;
      1: s[14] = 1'h1;
      2: s[13] = 1'h1;
      3, 4, 5: s[7+c] = 1'h1;
      6: s[9] = 1'h1;
      7: s[8] = 1'h1;
      default: s[c-8] = 1'h1;
    endcase
    return oaa_sources_t'(s);
  endfunction : one

  task automatic wait_rate(input logic w, output int n);
    n = 0;
    while (rate !== w && n < 40) begin
      @(posedge aclk);
      n++;
    end
    chk(rate, w);
  endtask : wait_rate

  task automatic t_reset();
    rd(OAA_ADDR_CTRL, v);
    chk(v, 32'h0000_2154);
    chk({glyph, hrs, tsp, acool}, 4'h8);
    rd(OAA_ADDR_PERIOD, v);
    chk(v, 32'h4);
    rd(OAA_ADDR_OC_HYS, v);
    chk(v, 32'h1);
    wr(8'h1C, 32'h1, r);
    chk(r, OAA_RESP_SLVERR);
  endtask : t_reset

  task automatic t_route();
    mode <= oaa_mode_t'(6'h2A);
    for (int c = 0; c < 16; c++) begin
      wr(OAA_ADDR_CTRL, 32'h2100 | (c << 4) | c, r);
      src <= one(c);
      settle(3);
      chk({aux3, aux2}, {2{c != 0 && c != 6}});
      src <= ~one(c);
      settle(3);
      chk({aux3, aux2}, 2'h0);
    end
  endtask : t_route

  task automatic t_select();
    wr(OAA_ADDR_CTRL, 32'h3E44, r);
    chk(mlim, 1'h0);
    chk({glyph, hrs, tsp, acool}, 4'h7);
    mode <= oaa_mode_t'(6'h18);
    src <= one(2);
    wr(OAA_ADDR_CTRL, 32'h2822, r);
    settle(3);
    chk({mlim, aux2}, 2'h2);
    wr(OAA_ADDR_CTRL, 32'h2888, r);
    rd(OAA_ADDR_CTRL, v);
    chk(v[7:0], 8'h22);
    mode <= oaa_mode_t'(6'h1C);
    wr(OAA_ADDR_CTRL, 32'h2833, r);
    rd(OAA_ADDR_CTRL, v);
    chk(v[7:0], 8'h66);
    mode <= oaa_mode_t'(6'h20);
    rd(OAA_ADDR_CTRL, v);
    chk(v[3:0], 4'h2);
  endtask : t_select

  task automatic t_rate();
    int t0;
    mode <= oaa_mode_t'(6'h2A);
    wr(OAA_ADDR_PERIOD, 32'h2, r);
    wr(OAA_ADDR_ALMVAL, 32'h5, r);
    settle(20);
    pv <= 16'h000A;
    wait_rate(1'h1, t0);
    wait_rate(1'h0, t0);
    chk(t0, 32'h8);
    pv <= 16'h000F;
    settle(40);
    chk(rate, 1'h0);
    pv <= 16'h0015;
    wait_rate(1'h1, t0);
    chk(t0 <= 9, 1'h1);
  endtask : t_rate

  task automatic t_oc();
    wr(OAA_ADDR_OC_THR, 32'h64, r);
    wr(OAA_ADDR_OC_HYS, 32'hA, r);
    lvl <= 10'h065;
    settle(4);
    chk(oc, 1'h1);
    lvl <= 10'h05F;
    settle(4);
    chk(oc, 1'h1);
    lvl <= 10'h059;
    settle(4);
    chk(oc, 1'h0);
    wr(OAA_ADDR_CTRL, 32'h0100, r);
    lvl <= 10'h065;
    settle(4);
    chk(oc, 1'h0);
    for (int k = 0; k < 5; k++) begin
      wr(OAA_ADDR_CTRL, 32'h6100, r);
      lvl <= 10'h065;
      settle(4);
      lvl <= 10'h000;
      settle(4);
      chk(oc, 1'h1);
      case (k)
        0: wr(OAA_ADDR_CMD, 32'h1, r);
        1: fkey <= 1'h1;
        2: ev <= 1'h1;
        3: mode <= oaa_mode_t'(6'h2B);
        default: wr(OAA_ADDR_OC_THR, 32'h1F4, r);
      endcase
      settle(2);
      fkey <= 1'h0;
      ev <= 1'h0;
      settle(8);
      chk(oc, 1'h0);
      mode <= oaa_mode_t'(6'h2A);
    end
    chk(lc_n, 32'h3);
  endtask : t_oc

  initial begin
    settle(2);
    aresetn <= 1'h1;
    t_reset();
    t_route();
    t_select();
    t_rate();
    t_oc();
    end_sim();
  end
endmodule : output_assign_alarm_options_bench
